// ===== common/shortage_pkg.sv
`default_nettype none
package shortage_pkg;

  // ----------------------------------------
  // clock and time base
  // ----------------------------------------
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned TICK_MS      = 100;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;

  // ----------------------------------------
  // register offsets (byte addresses, one 32-bit word apart)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_DETECT    = 8'h04;
  localparam logic [7:0] ADDR_RELEASE   = 8'h08;
  localparam logic [7:0] ADDR_RESERVED  = 8'h0c;
  localparam logic [7:0] ADDR_SPD1_FREQ = 8'h10;
  localparam logic [7:0] ADDR_SPD1_VOLT = 8'h14;
  localparam logic [7:0] ADDR_SPD2_FREQ = 8'h18;
  localparam logic [7:0] ADDR_SPD2_VOLT = 8'h1c;
  localparam logic [7:0] ADDR_SPD3_FREQ = 8'h20;
  localparam logic [7:0] ADDR_SPD3_VOLT = 8'h24;
  localparam logic [7:0] ADDR_STATUS    = 8'h28;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h2c;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h30;

  // ----------------------------------------
  // control field positions
  // ----------------------------------------
  localparam int unsigned CTRL_POL_BIT     = 0;
  localparam int unsigned CTRL_INSEL_BIT   = 1;
  localparam int unsigned CTRL_ALARMSEL_BIT = 2;
  localparam int unsigned CTRL_CARRIER_LSB = 4;
  localparam int unsigned CARRIER_W        = 3;
  localparam logic [CARRIER_W-1:0] CARRIER_20K = 3'h0;
  localparam logic [CARRIER_W-1:0] CARRIER_RST = 3'h1;

  // ----------------------------------------
  // ranges in tenths (time 0.1 s, freq 0.1 hz), volts in 1 v
  // ----------------------------------------
  localparam logic [15:0] DETECT_MIN  = 16'h000a;
  localparam logic [15:0] DETECT_MAX  = 16'h04b0;
  localparam logic [15:0] DETECT_RST  = 16'h0064;
  localparam logic [15:0] RELEASE_MIN = 16'h0001;
  localparam logic [15:0] RELEASE_MAX = 16'h012c;
  localparam logic [15:0] RELEASE_RST = 16'h000a;
  localparam logic [15:0] FREQ_MIN    = 16'h012c;
  localparam logic [15:0] FREQ_MAX    = 16'h07d0;
  localparam logic [15:0] FREQ_MAX_HI = 16'h09c4;
  localparam logic [15:0] FREQ_RST    = 16'h02bc;
  localparam logic [15:0] VOLT_MIN    = 16'h0000;
  localparam logic [15:0] VOLT_MAX    = 16'h00c8;
  localparam logic [15:0] VOLT_RST    = 16'h0064;

  // ----------------------------------------
  // interrupt bits
  // ----------------------------------------
  localparam int unsigned IRQ_W        = 2;
  localparam int unsigned IRQ_SET_BIT  = 0;
  localparam int unsigned IRQ_CLR_BIT  = 1;

  localparam int unsigned NUM_SPEEDS = 3;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b001,
    ST_DETECT   = 3'b010,
    ST_SHORTAGE = 3'b100
  } shortage_state_e;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

endpackage
`default_nettype wire

// ===== hw/tick_divider.sv
`timescale 1ns/1ns
`default_nettype none
module tick_divider
  import shortage_pkg::*;
#(
  parameter int unsigned DIV = TICK_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic arst_n,
  output var  logic tick
);

  logic [31:0] count;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 32'h0;
      tick  <= 1'b0;
    end else if (count == 32'(DIV - 1)) begin
      count <= 32'h0;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick  <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== hw/preset_store.sv
`timescale 1ns/1ns
`default_nettype none
module preset_store
  import shortage_pkg::*;
#(
  parameter int unsigned DEPTH = 2 * NUM_SPEEDS
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        wr,
  input  wire logic [2:0]  waddr,
  input  wire logic [15:0] wdata,
  input  wire logic [2:0]  raddr,
  output var  logic [15:0] rdata
);

  // even entries hold frequency, odd entries voltage
  logic [15:0] mem [DEPTH];

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_entry
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          mem[gi] <= (gi % 2 == 0) ? FREQ_RST : VOLT_RST;
        end else if (wr && waddr == 3'(gi)) begin
          mem[gi] <= wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 16'h0;
    end else begin
      rdata <= (raddr < 3'(DEPTH)) ? mem[raddr] : 16'h0;
    end
  end

endmodule
`default_nettype wire

// ===== hw/shortage_timer.sv
`timescale 1ns/1ns
`default_nettype none
module shortage_timer
  import shortage_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire reg_req_s    req,
  output var  logic [31:0] rdata,
  input  wire logic        drive_on,
  input  wire logic        sensor_input_one,
  output var  logic        shortage_display_code,
  output var  logic        alarm_output_terminals,
  output var  logic        irq
);

  // ----------------------------------------
  // settings
  // ----------------------------------------
  logic                 input_polarity_select;
  logic                 shortage_input_select;
  logic                 alarm_output_select;
  logic [CARRIER_W-1:0] carrier_frequency_select;
  logic [15:0]          shortage_detect_time;
  logic [15:0]          shortage_release_time;
  logic [IRQ_W-1:0]     irq_status;
  logic [IRQ_W-1:0]     irq_mask;
  logic                 tick;
  logic                 shortage;
  shortage_state_e      state;
  logic [15:0]          detect_count;
  logic [15:0]          release_count;
  logic                 input_active;
  logic                 set_event;
  logic                 clr_event;
  logic                 rd_q;
  logic [7:0]           rd_addr_q;
  logic [15:0]          preset_rdata;
  logic                 preset_wr;
  logic [2:0]           preset_waddr;
  logic [2:0]           preset_raddr;
  logic [15:0]          freq_max;
  logic [15:0]          wval;

  assign wval = req.wdata[15:0];

  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    if (v < lo) begin
      return lo;
    end
    if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  assign freq_max = (carrier_frequency_select == CARRIER_20K) ? FREQ_MAX_HI : FREQ_MAX;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      input_polarity_select    <= 1'b0;
      shortage_input_select    <= 1'b0;
      alarm_output_select      <= 1'b0;
      carrier_frequency_select <= CARRIER_RST;
    end else if (req.wr && req.addr == ADDR_CTRL) begin
      input_polarity_select    <= req.wdata[CTRL_POL_BIT];
      shortage_input_select    <= req.wdata[CTRL_INSEL_BIT];
      alarm_output_select      <= req.wdata[CTRL_ALARMSEL_BIT];
      carrier_frequency_select <= req.wdata[CTRL_CARRIER_LSB +: CARRIER_W];
    end
  end

  // out-of-range writes are clamped rather than refused so the timer never sees a zero length
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      shortage_detect_time  <= DETECT_RST;
      shortage_release_time <= RELEASE_RST;
    end else if (req.wr && req.addr == ADDR_DETECT) begin
      shortage_detect_time <= clamp(wval, DETECT_MIN, DETECT_MAX);
    end else if (req.wr && req.addr == ADDR_RELEASE) begin
      shortage_release_time <= clamp(wval, RELEASE_MIN, RELEASE_MAX);
    end
  end

  // ----------------------------------------
  // speed presets
  // ----------------------------------------
  always_comb begin
    preset_wr    = 1'b0;
    preset_waddr = 3'h0;
    case (req.addr)
      ADDR_SPD1_FREQ: preset_waddr = 3'h0;
      ADDR_SPD1_VOLT: preset_waddr = 3'h1;
      ADDR_SPD2_FREQ: preset_waddr = 3'h2;
      ADDR_SPD2_VOLT: preset_waddr = 3'h3;
      ADDR_SPD3_FREQ: preset_waddr = 3'h4;
      ADDR_SPD3_VOLT: preset_waddr = 3'h5;
      default:        preset_waddr = 3'h7;
    endcase
    preset_wr = req.wr && (preset_waddr != 3'h7);
  end

  assign preset_raddr = preset_waddr;

  preset_store #(
    .DEPTH(2 * NUM_SPEEDS)
  ) u_presets (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .wr       (preset_wr),
    .waddr    (preset_waddr),
    .wdata    (preset_waddr[0] ? clamp(wval, VOLT_MIN, VOLT_MAX) : clamp(wval, FREQ_MIN, freq_max)),
    .raddr    (preset_raddr),
    .rdata    (preset_rdata)
  );

  // ----------------------------------------
  // timers
  // ----------------------------------------
  tick_divider #(
    .DIV(TICK_DIV)
  ) u_tick (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .tick     (tick)
  );

  assign input_active = sensor_input_one ^ ~input_polarity_select;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state         <= ST_IDLE;
      detect_count  <= 16'h0;
      release_count <= 16'h0;
      shortage      <= 1'b0;
    end else if (!shortage_input_select) begin
      state         <= ST_IDLE;
      detect_count  <= 16'h0;
      release_count <= 16'h0;
      shortage      <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          detect_count <= 16'h0;
          if (drive_on && input_active) begin
            state <= ST_DETECT;
          end
        end
        ST_DETECT: begin
          if (!(drive_on && input_active)) begin
            state        <= ST_IDLE;
            detect_count <= 16'h0;
          end else if (tick) begin
            if (detect_count + 16'h1 >= shortage_detect_time) begin
              state         <= ST_SHORTAGE;
              shortage      <= 1'b1;
              release_count <= 16'h0;
            end else begin
              detect_count <= detect_count + 16'h1;
            end
          end
        end
        ST_SHORTAGE: begin
          if (input_active) begin
            release_count <= 16'h0;
          end else if (tick) begin
            if (release_count + 16'h1 >= shortage_release_time) begin
              state    <= ST_IDLE;
              shortage <= 1'b0;
            end else begin
              release_count <= release_count + 16'h1;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign set_event = (state == ST_DETECT) && tick && drive_on && input_active
                     && (detect_count + 16'h1 >= shortage_detect_time) && shortage_input_select;
  assign clr_event = (state == ST_SHORTAGE) && tick && !input_active
                     && (release_count + 16'h1 >= shortage_release_time) && shortage_input_select;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      shortage_display_code  <= 1'b0;
      alarm_output_terminals <= 1'b0;
    end else begin
      shortage_display_code  <= shortage;
      alarm_output_terminals <= shortage && alarm_output_select;
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= '0;
      irq_mask   <= '0;
    end else begin
      if (req.wr && req.addr == ADDR_IRQ_MASK) begin
        irq_mask <= req.wdata[IRQ_W-1:0];
      end
      // a new event wins over a write-one-to-clear in the same cycle
      irq_status <= (irq_status & ~((req.wr && req.addr == ADDR_IRQ_STAT) ? req.wdata[IRQ_W-1:0] : '0))
                    | {clr_event, set_event};
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_q      <= 1'b0;
      rd_addr_q <= 8'h0;
    end else begin
      rd_q      <= req.rd;
      rd_addr_q <= req.addr;
    end
  end

  // preset data is registered in the store, so the mux settles in the same cycle
  always_comb begin
    rdata = 32'h0;
    if (rd_q) begin
      case (rd_addr_q)
        ADDR_CTRL:      rdata = {25'h0, carrier_frequency_select, 1'b0, alarm_output_select,
                                 shortage_input_select, input_polarity_select};
        ADDR_DETECT:    rdata = {16'h0, shortage_detect_time};
        ADDR_RELEASE:   rdata = {16'h0, shortage_release_time};
        ADDR_RESERVED:  rdata = 32'h0;
        ADDR_SPD1_FREQ, ADDR_SPD1_VOLT, ADDR_SPD2_FREQ,
        ADDR_SPD2_VOLT, ADDR_SPD3_FREQ, ADDR_SPD3_VOLT: rdata = {16'h0, preset_rdata};
        ADDR_STATUS:    rdata = {29'h0, state == ST_SHORTAGE, state == ST_DETECT, shortage};
        ADDR_IRQ_STAT:  rdata = {30'h0, irq_status};
        ADDR_IRQ_MASK:  rdata = {30'h0, irq_mask};
        default:        rdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_disabled_idle;
    @(posedge core_clk) disable iff (!arst_n) !shortage_input_select |=> !shortage;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("shortage set while disabled");

  property p_alarm_follows;
    @(posedge core_clk) disable iff (!arst_n) alarm_output_terminals |-> shortage_display_code;
  endproperty
  a_alarm_follows: assert property (p_alarm_follows) else $error("alarm without display");

  // outputs are a register behind the flag, so both steps land one edge after it
  sequence s_shown;
    ##1 shortage_display_code;
  endsequence

  sequence s_blanked;
    ##1 !shortage_display_code && !alarm_output_terminals;
  endsequence

  property p_set_show;
    @(posedge core_clk) disable iff (!arst_n) set_event |=> s_shown;
  endproperty
  a_set_show: assert property (p_set_show) else $error("display not shown after expiry");

  property p_clear_blank;
    @(posedge core_clk) disable iff (!arst_n)
      clr_event && shortage_input_select |=> s_blanked;
  endproperty
  a_clear_blank: assert property (p_clear_blank) else $error("display kept after release");

  property p_detect_needs_drive;
    @(posedge core_clk) disable iff (!arst_n) (state == ST_DETECT) && !drive_on |=> state != ST_SHORTAGE;
  endproperty
  a_detect_needs_drive: assert property (p_detect_needs_drive) else $error("expiry without drive");

  property p_detect_range;
    @(posedge core_clk) disable iff (!arst_n)
      shortage_detect_time >= DETECT_MIN && shortage_detect_time <= DETECT_MAX;
  endproperty
  a_detect_range: assert property (p_detect_range) else $error("detect time out of range");

  property p_release_range;
    @(posedge core_clk) disable iff (!arst_n)
      shortage_release_time >= RELEASE_MIN && shortage_release_time <= RELEASE_MAX;
  endproperty
  a_release_range: assert property (p_release_range) else $error("release time out of range");

  property p_restart;
    @(posedge core_clk) disable iff (!arst_n)
      (state == ST_DETECT) && !(drive_on && input_active) |=> detect_count == 16'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("detect count not restarted");

  property p_release_restart;
    @(posedge core_clk) disable iff (!arst_n)
      (state == ST_SHORTAGE) && input_active |=> release_count == 16'h0;
  endproperty
  a_release_restart: assert property (p_release_restart) else $error("release count not restarted");

  property p_tick_step;
    @(posedge core_clk) disable iff (!arst_n)
      (state == ST_DETECT) && drive_on && input_active && shortage_input_select && !tick |=> $stable(detect_count);
  endproperty
  a_tick_step: assert property (p_tick_step) else $error("detect count moved without tick");

  property p_shortage_holds;
    @(posedge core_clk) disable iff (!arst_n)
      (state == ST_SHORTAGE) && input_active && shortage_input_select |=> shortage;
  endproperty
  a_shortage_holds: assert property (p_shortage_holds) else $error("flag cleared while input active");

  property p_alarm_select;
    @(posedge core_clk) disable iff (!arst_n) !alarm_output_select |=> !alarm_output_terminals;
  endproperty
  a_alarm_select: assert property (p_alarm_select) else $error("alarm driven while not selected");

  property p_reserved_zero;
    @(posedge core_clk) disable iff (!arst_n) rd_q && rd_addr_q == ADDR_RESERVED |-> rdata == 32'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved slot not zero");

endmodule
`default_nettype wire

// ===== tb/feeder_overflow_sensor.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// overflow sensor at the feeder chute
// ----------------------------------------
module feeder_overflow_sensor (
  input  wire logic core_clk,
  input  wire logic parts_present,
  input  wire logic active_high,
  output var  logic sensor_input_one
);
  // parts in front of the sensor hold it inactive; a gap leaves it active.
  // one cycle of lag, as a real sensor never answers in the same edge
  always_ff @(posedge core_clk) begin
    sensor_input_one <= parts_present ? ~active_high : active_high;
  end
endmodule
`default_nettype wire

// ===== tb/work_shortage_timer_speed_presets_test.sv
`timescale 1ns/1ns
`default_nettype none
module work_shortage_timer_speed_presets_test
  import shortage_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  // short tick keeps the run small; all waits below are in clock cycles, DIV of them to a tick
  localparam int unsigned DIV = 10;
  logic        core_clk = 1'b0;
  logic        arst_n;
  reg_req_s    req;
  logic [31:0] rdata;
  logic        drive_on;
  logic        parts_present;
  logic        active_high;
  logic        sensor_input_one;
  logic        shortage_display_code;
  logic        alarm_output_terminals;
  logic        irq;
  logic [15:0] v;
  logic [7:0]  a;
  int          failures = 0;
  int          num_checks = 0;
  localparam logic [7:0]  RA [13] = '{ADDR_CTRL, ADDR_DETECT, ADDR_RELEASE, ADDR_RESERVED,
    ADDR_SPD1_FREQ, ADDR_SPD1_VOLT, ADDR_SPD2_FREQ, ADDR_SPD2_VOLT, ADDR_SPD3_FREQ,
    ADDR_SPD3_VOLT, ADDR_IRQ_STAT, ADDR_IRQ_MASK, 8'h40};
  localparam logic [15:0] RV [13] = '{16'h0010, DETECT_RST, RELEASE_RST, 16'h0000,
    FREQ_RST, VOLT_RST, FREQ_RST, VOLT_RST, FREQ_RST, VOLT_RST, 16'h0000, 16'h0000, 16'h0000};

  always #10 core_clk = ~core_clk;

  shortage_timer #(.TICK_DIV(DIV)) u_dut (
    .core_clk               (core_clk),
    .arst_n                 (arst_n),
    .req                    (req),
    .rdata                  (rdata),
    .drive_on               (drive_on),
    .sensor_input_one       (sensor_input_one),
    .shortage_display_code  (shortage_display_code),
    .alarm_output_terminals (alarm_output_terminals),
    .irq                    (irq)
  );

  feeder_overflow_sensor u_sensor (
    .core_clk         (core_clk),
    .parts_present    (parts_present),
    .active_high      (active_high),
    .sensor_input_one (sensor_input_one)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (failures == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // both strobe tasks start and end just after a rising edge
  task automatic wr(input logic [7:0] ad, input logic [15:0] d);
    req <= '{ad, {16'h0000, d}, 1'b1, 1'b0};
    @(posedge core_clk);
    req <= '0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    req <= '{ad, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk);
    req <= '0;
    #1 check(rdata, exp);
    @(posedge core_clk);
  endtask

  task automatic chk_out(input int n, input logic d, input logic al, input logic q);
    cyc(n);
    #1 check({31'h0, shortage_display_code}, {31'h0, d});
    check({31'h0, alarm_output_terminals}, {31'h0, al});
    check({31'h0, irq}, {31'h0, q});
    @(posedge core_clk);
  endtask

  function automatic logic [15:0] clampv(input logic [15:0] x, input logic [15:0] lo,
                                         input logic [15:0] hi);
    return (x < lo) ? lo : ((x > hi) ? hi : x);
  endfunction

  function automatic logic [15:0] expect_val(input logic [7:0] ad, input logic [15:0] x,
                                             input logic wide);
    case (ad)
      ADDR_DETECT:  return clampv(x, DETECT_MIN, DETECT_MAX);
      ADDR_RELEASE: return clampv(x, RELEASE_MIN, RELEASE_MAX);
      ADDR_SPD1_FREQ, ADDR_SPD2_FREQ, ADDR_SPD3_FREQ: begin
        return clampv(x, FREQ_MIN, wide ? FREQ_MAX_HI : FREQ_MAX);
      end
      ADDR_SPD1_VOLT, ADDR_SPD2_VOLT, ADDR_SPD3_VOLT: return clampv(x, VOLT_MIN, VOLT_MAX);
      default: return 16'h0000;
    endcase
  endfunction

  // ----------------------------------------
  // watchdog and main sequence
  // ----------------------------------------
  initial begin
    cyc(20000);
    failures++;
    end_of_test();
  end

  initial begin
    arst_n = 1'b0;
    req = '0;
    drive_on = 1'b0;
    parts_present = 1'b1;
    active_high = 1'b0;
    void'($urandom(48137));
    cyc(6);
    arst_n <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 13; i++) rd(RA[i], {16'h0000, RV[i]});
    // all-ones and zero on two of every four writes, random values between; second pass with carrier code zero
    for (int w = 0; w < 2; w++) begin
      wr(ADDR_CTRL, w ? 16'h0000 : 16'h0010);
      for (int i = 0; i < 40; i++) begin
        a = RA[1 + $urandom_range(0, 8)];
        v = (i % 4 == 0) ? 16'hffff : ((i % 4 == 1) ? 16'h0000 : 16'($urandom_range(0, 2600)));
        wr(a, v);
        rd(a, {16'h0000, expect_val(a, v, w[0])});
      end
    end
    wr(ADDR_CTRL, 16'h0016);
    wr(ADDR_DETECT, 16'h000a);
    wr(ADDR_RELEASE, 16'h0003);
    wr(ADDR_IRQ_MASK, 16'h0001);
    parts_present <= 1'b0;
    chk_out(150, 1'b0, 1'b0, 1'b0);
    drive_on <= 1'b1;
    cyc(60);
    parts_present <= 1'b1;
    cyc(30);
    parts_present <= 1'b0;
    chk_out(85, 1'b0, 1'b0, 1'b0);
    chk_out(30, 1'b1, 1'b1, 1'b1);
    rd(ADDR_STATUS, 32'h5);
    rd(ADDR_IRQ_STAT, 32'h1);
    wr(ADDR_IRQ_STAT, 16'h0001);
    chk_out(2, 1'b1, 1'b1, 1'b0);
    parts_present <= 1'b1;
    chk_out(15, 1'b1, 1'b1, 1'b0);
    chk_out(30, 1'b0, 1'b0, 1'b0);
    wr(ADDR_IRQ_MASK, 16'h0000);
    // polarity flipped: a low sensor no longer counts
    wr(ADDR_CTRL, 16'h0017);
    active_high <= 1'b1;
    chk_out(115, 1'b0, 1'b0, 1'b0);
    parts_present <= 1'b0;
    chk_out(115, 1'b1, 1'b1, 1'b0);
    parts_present <= 1'b1;
    chk_out(45, 1'b0, 1'b0, 1'b0);
    wr(ADDR_CTRL, 16'h0013);
    parts_present <= 1'b0;
    chk_out(115, 1'b1, 1'b0, 1'b0);
    parts_present <= 1'b1;
    chk_out(45, 1'b0, 1'b0, 1'b0);
    wr(ADDR_CTRL, 16'h0014);
    active_high <= 1'b0;
    parts_present <= 1'b0;
    chk_out(150, 1'b0, 1'b0, 1'b0);
    rd(ADDR_STATUS, 32'h0);
    rd(ADDR_IRQ_STAT, 32'h3);
    end_of_test();
  end
endmodule
`default_nettype wire
